//--- tsrf_pkg.sv
// Constants, types and lookup tables of the switch timer,
// restart limiter and fail output block.
// Assumes a 100 MHz core clock and word-wide AHB-Lite access.
`default_nettype none
package tsrf_pkg;
  localparam int unsigned CLK_MHZ = 100;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_B = 8'h26;
  localparam logic [7:0] IDX_RESTART = 8'h28;
  localparam logic [7:0] IDX_FAILOUT = 8'h29;
  localparam logic [7:0] IDX_IRQ_ST  = 8'h30;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h31;
  localparam int unsigned ADDR_W     = 10;

  localparam logic [7:0] RST_TIMER_B = 8'h00;
  localparam logic [7:0] RST_RESTART = 8'h40;
  localparam logic [7:0] RST_FAILOUT = 8'h00;
  localparam logic [5:0] RST_IRQ_MSK = 6'h00;

  // Field positions
  localparam int unsigned TB_ON_LSB   = 4;
  localparam int unsigned TB_PER_LSB  = 0;
  localparam int unsigned RS_LIM_LSB  = 4;
  localparam int unsigned RS_TAL_LSB  = 0;
  localparam int unsigned FO_LEN_BIT  = 5;
  localparam int unsigned FO_POL_BIT  = 4;
  localparam int unsigned FO_SRC_LSB  = 1;
  localparam logic [3:0]  ON_CODE_OFF = 4'h0;
  localparam logic [3:0]  ON_CODE_ON  = 4'hf;

  // Interrupt status bit positions
  localparam int unsigned ST_OVF   = 0;
  localparam int unsigned ST_SUP   = 1;
  localparam int unsigned ST_WDOG  = 2;
  localparam int unsigned ST_LWAKE = 3;
  localparam int unsigned ST_BWAKE = 4;
  localparam int unsigned ST_FSAFE = 5;
  localparam int unsigned ST_W     = 6;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Reset pulse lengths in microseconds
  localparam int unsigned RST_SHORT_US = 2000;
  localparam int unsigned RST_LONG_US  = 15000;

  typedef enum logic [2:0] {
    SRC_SUPPLY = 3'h0,
    SRC_WDOG   = 3'h1,
    SRC_RSVD_A = 3'h2,
    SRC_LWAKE  = 3'h3,
    SRC_BWAKE  = 3'h4,
    SRC_FSAFE  = 3'h5,
    SRC_GPO    = 3'h6,
    SRC_RSVD_B = 3'h7
  } tsrf_src_e;

  typedef enum logic [1:0] {
    PS_IDLE = 2'h1,
    PS_LOW  = 2'h2
  } tsrf_pulse_e;

  typedef struct packed {
    logic supplyIrq;
    logic watchdogEvent;
    logic localWakeRequest;
    logic busWakePattern;
    logic failSafeEntry;
  } tsrf_events_s;

  // On time in units of 0.1 ms
  function automatic int unsigned on_time_tenth_ms(input logic [3:0] code);
    case (code)
      4'h1:    return 1;
      4'h2:    return 3;
      4'h3:    return 5;
      4'h4:    return 10;
      4'h5:    return 100;
      4'h6:    return 200;
      4'h7:    return 300;
      4'h8:    return 400;
      4'h9:    return 500;
      4'ha:    return 600;
      4'hb:    return 800;
      4'hc:    return 1000;
      4'hd:    return 1500;
      4'he:    return 2000;
      default: return 0;
    endcase
  endfunction

  function automatic int unsigned period_ms(input logic [2:0] code);
    case (code)
      3'h0:    return 10;
      3'h1:    return 20;
      3'h2:    return 50;
      3'h3:    return 100;
      3'h4:    return 200;
      3'h5:    return 500;
      3'h6:    return 1000;
      default: return 2000;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- tsrf_switch_timer.sv
// High-side switch timer: on time within a repeating period.
// Assumes codes come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tsrf_switch_timer
  import tsrf_pkg::*;
#(
  parameter int unsigned TENTH_MS_CYCLES = CLK_MHZ * 100
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Configuration
  input  wire logic [3:0] onCode,
  input  wire logic [2:0] perCode,
  // Switch drive
  output var  logic       switchOn,
  output var  logic       switchOe
);
  generate
    if (TENTH_MS_CYCLES < 1) begin : g_chk
      $error("TENTH_MS_CYCLES must be at least 1");
    end
  endgenerate

  logic [31:0] cnt;
  wire  [31:0] onCyc   = 32'(on_time_tenth_ms(onCode) * TENTH_MS_CYCLES);
  wire  [31:0] perCyc  = 32'(period_ms(perCode) * 10 * TENTH_MS_CYCLES);
  // Shrinking the period mid-count wraps at once, no long stall
  wire         wrap    = (cnt >= perCyc - 32'h1);
  wire         isOff   = (onCode == ON_CODE_OFF);
  wire         isFull  = (onCode == ON_CODE_ON);
  wire         next_on = isFull | (!isOff & (cnt < onCyc));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt      <= 32'h0;
      switchOn <= 1'b0;
      switchOe <= 1'b0;
    end else begin
      cnt      <= wrap ? 32'h0 : cnt + 32'h1;
      switchOn <= next_on;
      switchOe <= !isOff;
    end
  end
endmodule
`default_nettype wire

//--- tsrf_reset_pulse.sv
// Drives the active-low reset output low for a chosen length.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tsrf_reset_pulse
  import tsrf_pkg::*;
#(
  parameter int unsigned SHORT_CYCLES = RST_SHORT_US * CLK_MHZ,
  parameter int unsigned LONG_CYCLES  = RST_LONG_US * CLK_MHZ
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Request
  input  wire logic start,
  input  wire logic longPulse,
  // Pin
  output var  logic resetOutputLow
);
  generate
    if (SHORT_CYCLES < 1 || LONG_CYCLES < 1) begin : g_chk
      $error("Reset pulse lengths must be at least one cycle");
    end
  endgenerate

  tsrf_pulse_e state;
  logic [31:0] cnt;
  wire  [31:0] lenCyc = longPulse ? 32'(LONG_CYCLES) : 32'(SHORT_CYCLES);
  wire         done   = (cnt == 32'h1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state          <= PS_IDLE;
      cnt            <= 32'h0;
      resetOutputLow <= 1'b1;
    end else begin
      case (state)
        PS_IDLE: begin
          if (start) begin
            state          <= PS_LOW;
            cnt            <= lenCyc;
            resetOutputLow <= 1'b0;
          end
        end
        PS_LOW: begin
          cnt <= cnt - 32'h1;
          if (done) begin
            state          <= PS_IDLE;
            resetOutputLow <= 1'b1;
          end
        end
        default: begin
          state          <= PS_IDLE;
          resetOutputLow <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- tsrf_timer_restart_failout.sv
// Switch timer, restart limiter and fail output control with
// AHB-Lite register access and one level interrupt.
// Assumes event inputs are single-cycle pulses on clk_sys.
//
// Behaviour
// - On-time code zero keeps the high-side switch off and undriven.
// - On-time code all ones keeps the switch on continuously.
// - Middle on-time codes give 0.1 to 200 ms on per period, ascending.
// - Period code selects 10 to 2000 ms, ascending.
// - Each allowed restart entry increments a tally, read as four bits saturating at 15.
// - Limit field 0 to 15 allows 1 to 16 restart entries.
// - Past the limit the device goes to sleep instead of restarting.
// - Each restart outside a running pulse pulses the reset output low for 2 or 15 ms.
// - Polarity bit: 0 gives active low, 1 gives active high fail output.
// - Source code 110b makes the fail pin a plain output at polarity.
// - Source code selects supply, watchdog, local, bus wake or fail-safe.
// - A write-one-clear flag sets when an entry is refused past the limit.
`timescale 1ns/100ps
`default_nettype none
module tsrf_timer_restart_failout
  import tsrf_pkg::*;
#(
  parameter int unsigned TENTH_MS_CYCLES = CLK_MHZ * 100,
  parameter int unsigned SHORT_CYCLES    = RST_SHORT_US * CLK_MHZ,
  parameter int unsigned LONG_CYCLES     = RST_LONG_US * CLK_MHZ
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output var  logic [31:0]  hrdata,
  output var  logic         hreadyout,
  output var  logic         hresp,
  // Core events
  input  wire tsrf_events_s events,
  input  wire logic         restartEntry,
  // Outputs
  output var  logic         highSideSwitch,
  output var  logic         highSideSwitchOe,
  output var  logic         resetOutputLow,
  output var  logic         failIndicatorPin,
  output var  logic         sleepRequest,
  output var  logic         irq
);
  // Configuration registers
  logic [3:0] timerBOnTime;
  logic [2:0] timerBPeriod;
  logic [3:0] restartLimit;
  logic [4:0] restartTally;
  logic       resetPulseLen;
  logic       failoutPolarity;
  logic [2:0] failoutSource;
  logic [ST_W-1:0] irqStatus;
  logic [ST_W-1:0] irqMask;

  // Data phase capture
  logic             wrPend;
  logic [ADDR_W-1:0] wrAddr;

  // Address phase decode
  wire addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire [ADDR_W-1:0] reqAddr = haddr[ADDR_W-1:0];

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    return (a == {idx, 2'b00});
  endfunction

  // Register images; reserved bits are zero
  wire [7:0] imgTimer = {timerBOnTime, 1'b0, timerBPeriod};
  // Tally saturates at 15 on read; bit 4 only tracks the 16th entry
  wire [3:0] tallyRead = restartTally[4] ? 4'hf : restartTally[3:0];
  wire [7:0] imgRestart = {restartLimit, tallyRead};
  wire [7:0] imgFailout = {2'b00, resetPulseLen, failoutPolarity,
                           failoutSource, 1'b0};

  wire [7:0] rdMux =
    hit(reqAddr, IDX_TIMER_B) ? imgTimer :
    hit(reqAddr, IDX_RESTART) ? imgRestart :
    hit(reqAddr, IDX_FAILOUT) ? imgFailout :
    hit(reqAddr, IDX_IRQ_ST)  ? {2'b00, irqStatus} :
    hit(reqAddr, IDX_IRQ_MSK) ? {2'b00, irqMask} :
    8'h00;

  // Data phase write strobes
  wire wrTimer   = wrPend & hit(wrAddr, IDX_TIMER_B);
  wire wrRestart = wrPend & hit(wrAddr, IDX_RESTART);
  wire wrFailout = wrPend & hit(wrAddr, IDX_FAILOUT);
  wire wrSt      = wrPend & hit(wrAddr, IDX_IRQ_ST);
  wire wrMsk     = wrPend & hit(wrAddr, IDX_IRQ_MSK);

  // Restart decision
  wire [3:0] tallyClr   = wrRestart ? hwdata[RS_TAL_LSB +: 4] : 4'h0;
  wire       clrAny     = |tallyClr;
  // Entry number tally+1 is allowed while it does not pass limit+1
  wire       overLimit  = (restartTally > {1'b0, restartLimit});
  wire       allowEntry = restartEntry & !overLimit;
  wire       denyEntry  = restartEntry & overLimit;

  wire [4:0] tallyAfterClr = clrAny ?
    {1'b0, restartTally[3:0] & ~tallyClr} : restartTally;
  wire [4:0] tallyInc = (tallyAfterClr == 5'h10) ?
    tallyAfterClr : tallyAfterClr + 5'h1;
  wire [4:0] next_tally = allowEntry ? tallyInc : tallyAfterClr;

  // Status events; a set in the clear cycle wins
  wire [ST_W-1:0] evSet;
  assign evSet[ST_OVF]   = denyEntry;
  assign evSet[ST_SUP]   = events.supplyIrq;
  assign evSet[ST_WDOG]  = events.watchdogEvent;
  assign evSet[ST_LWAKE] = events.localWakeRequest;
  assign evSet[ST_BWAKE] = events.busWakePattern;
  assign evSet[ST_FSAFE] = events.failSafeEntry;

  wire [ST_W-1:0] stClr = wrSt ? hwdata[ST_W-1:0] : '0;
  wire [ST_W-1:0] next_status = (irqStatus & ~stClr) | evSet;

  // Fail output condition select
  wire selFlag =
    (failoutSource == SRC_SUPPLY) ? irqStatus[ST_SUP] :
    (failoutSource == SRC_WDOG)   ? irqStatus[ST_WDOG] :
    (failoutSource == SRC_LWAKE)  ? irqStatus[ST_LWAKE] :
    (failoutSource == SRC_BWAKE)  ? irqStatus[ST_BWAKE] :
    (failoutSource == SRC_FSAFE)  ? irqStatus[ST_FSAFE] :
    1'b0;
  wire isGpo = (failoutSource == SRC_GPO);
  // Reserved codes never assert, so the pin idles inactive
  wire next_fail = isGpo ? failoutPolarity
                         : (selFlag ~^ failoutPolarity);

  // Bus pipeline
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPend    <= 1'b0;
      wrAddr    <= '0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wrPend    <= addrPhase & hwrite & (hsize == HSIZE_WORD);
      wrAddr    <= reqAddr;
      hrdata    <= addrPhase ? {24'h0, rdMux} : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timerBOnTime    <= RST_TIMER_B[TB_ON_LSB +: 4];
      timerBPeriod    <= RST_TIMER_B[TB_PER_LSB +: 3];
      restartLimit    <= RST_RESTART[RS_LIM_LSB +: 4];
      resetPulseLen   <= RST_FAILOUT[FO_LEN_BIT];
      failoutPolarity <= RST_FAILOUT[FO_POL_BIT];
      failoutSource   <= RST_FAILOUT[FO_SRC_LSB +: 3];
      irqMask         <= RST_IRQ_MSK;
    end else begin
      if (wrTimer) begin
        timerBOnTime <= hwdata[TB_ON_LSB +: 4];
        timerBPeriod <= hwdata[TB_PER_LSB +: 3];
      end
      if (wrRestart) begin
        restartLimit <= hwdata[RS_LIM_LSB +: 4];
      end
      if (wrFailout) begin
        resetPulseLen   <= hwdata[FO_LEN_BIT];
        failoutPolarity <= hwdata[FO_POL_BIT];
        failoutSource   <= hwdata[FO_SRC_LSB +: 3];
      end
      if (wrMsk) begin
        irqMask <= hwdata[ST_W-1:0];
      end
    end
  end

  // Tally, status and block outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      restartTally     <= {1'b0, RST_RESTART[RS_TAL_LSB +: 4]};
      irqStatus        <= '0;
      sleepRequest     <= 1'b0;
      failIndicatorPin <= 1'b1;
      irq              <= 1'b0;
    end else begin
      restartTally     <= next_tally;
      irqStatus        <= next_status;
      sleepRequest     <= denyEntry;
      failIndicatorPin <= next_fail;
      irq              <= |(irqStatus & irqMask);
    end
  end

  // Switch timer
  tsrf_switch_timer #(
    .TENTH_MS_CYCLES (TENTH_MS_CYCLES)
  ) u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .onCode   (timerBOnTime),
    .perCode  (timerBPeriod),
    .switchOn (highSideSwitch),
    .switchOe (highSideSwitchOe)
  );

  // Reset pulse; a new entry during a pulse does not restart it
  tsrf_reset_pulse #(
    .SHORT_CYCLES (SHORT_CYCLES),
    .LONG_CYCLES  (LONG_CYCLES)
  ) u_pulse (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .start          (allowEntry),
    .longPulse      (resetPulseLen),
    .resetOutputLow (resetOutputLow)
  );
endmodule
`default_nettype wire

//--- tsrf_chk.sv
// Checker of the switch timer, restart limiter and fail output block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module tsrf_chk
  import tsrf_pkg::*;
#(
  parameter int unsigned TENTH_MS_CYCLES = CLK_MHZ * 100,
  parameter int unsigned SHORT_CYCLES    = RST_SHORT_US * CLK_MHZ,
  parameter int unsigned LONG_CYCLES     = RST_LONG_US * CLK_MHZ
) (
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         rst,
  // Bus
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [2:0]   hsize,
  input wire logic [31:0]  hwdata,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  // Core side and pins
  input wire tsrf_events_s events,
  input wire logic         restartEntry,
  input wire logic         highSideSwitch,
  input wire logic         highSideSwitchOe,
  input wire logic         resetOutputLow,
  input wire logic         failIndicatorPin,
  input wire logic         sleepRequest
);
  logic       wPend;
  logic [7:0] wIdx;
  logic [7:0] shTim;
  logic [5:0] shFo;
  int         lowCnt;
  wire  logic take = hsel && hready && htrans == HTRANS_NONSEQ && hwrite && hsize == HSIZE_WORD;
  wire  logic [2:0] src = shFo[3:1];
  wire  logic selEv = (src == SRC_SUPPLY && events.supplyIrq) || (src == SRC_WDOG && events.watchdogEvent) ||
                      (src == SRC_LWAKE && events.localWakeRequest) || (src == SRC_BWAKE && events.busWakePattern) ||
                      (src == SRC_FSAFE && events.failSafeEntry);

  // Shadows of the bus writes; the pulse length bit is assumed stable during a pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wPend  <= 1'b0;
      wIdx   <= 8'h00;
      shTim  <= RST_TIMER_B;
      shFo   <= RST_FAILOUT[5:0];
      lowCnt <= 0;
    end else begin
      wPend  <= take;
      wIdx   <= haddr[9:2];
      shTim  <= (wPend && wIdx == IDX_TIMER_B) ? hwdata[7:0] : shTim;
      shFo   <= (wPend && wIdx == IDX_FAILOUT) ? hwdata[5:0] : shFo;
      lowCnt <= resetOutputLow ? 0 : lowCnt + 1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_oe_off;
    (shTim[7:4] == ON_CODE_OFF)[*4] |-> !highSideSwitchOe && !highSideSwitch;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("switch driven with on code zero");
  property p_full_on;
    (shTim[7:4] == ON_CODE_ON)[*4] |-> highSideSwitch && highSideSwitchOe;
  endproperty
  a_full_on: assert property (p_full_on) else $error("switch not fully on");
  property p_oe_on;
    (shTim[7:4] != ON_CODE_OFF)[*4] |-> highSideSwitchOe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("switch undriven with nonzero on code");
  property p_low_len;
    $rose(resetOutputLow) |-> lowCnt == (shFo[5] ? LONG_CYCLES : SHORT_CYCLES);
  endproperty
  a_low_len: assert property (p_low_len) else $error("reset low pulse length wrong");
  property p_low_cause;
    $fell(resetOutputLow) |-> $past(restartEntry);
  endproperty
  a_low_cause: assert property (p_low_cause) else $error("reset pulse without restart entry");
  property p_sleep_cause;
    sleepRequest |-> $past(restartEntry) && !$fell(resetOutputLow);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("sleep request without cause");
  property p_gpo;
    (src == SRC_GPO && $stable(shFo))[*3] |-> failIndicatorPin == shFo[4];
  endproperty
  a_gpo: assert property (p_gpo) else $error("fail pin not at output level");
  property p_rsvd;
    ((src == SRC_RSVD_A || src == SRC_RSVD_B) && $stable(shFo))[*3] |-> failIndicatorPin == !shFo[4];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("fail pin active on reserved source");
  property p_fail_act;
    selEv && $stable(shFo) |-> ##2 failIndicatorPin == shFo[4];
  endproperty
  a_fail_act: assert property (p_fail_act) else $error("fail pin not active after event");
  property p_upper;
    hrdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits not zero");
endmodule

bind tsrf_timer_restart_failout tsrf_chk #(
  .TENTH_MS_CYCLES(TENTH_MS_CYCLES), .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)
) tsrf_chk_inst (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .events(events),
  .restartEntry(restartEntry), .highSideSwitch(highSideSwitch), .highSideSwitchOe(highSideSwitchOe),
  .resetOutputLow(resetOutputLow), .failIndicatorPin(failIndicatorPin), .sleepRequest(sleepRequest)
);
`default_nettype wire

//--- tsrf_host_mon.sv
// Host side watcher of the reset pin: pulse count and last low length.
// Assumes the host shares the block's clock.
`timescale 1ns/100ps
`default_nettype none
module tsrf_host_mon (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin from the device
  input  wire logic resetOutputLow,
  // Measurements
  output var  int   pulses,
  output var  int   lowLen
);
  int run;

  // Length counted in whole cycles at the sampling edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run    <= 0;
      pulses <= 0;
      lowLen <= 0;
    end else if (!resetOutputLow) begin
      run <= run + 1;
    end else if (run != 0) begin
      pulses <= pulses + 1;
      lowLen <= run;
      run    <= 0;
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// Testbench of the switch timer, restart limiter and fail output block.
// Assumes shortened timing parameters and a zero-wait bus slave.
`timescale 1ns/100ps
`default_nettype none
module tb
  import tsrf_pkg::*;
;
  localparam int TQ = 2;
  localparam int SH = 20;
  localparam int LG = 150;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = HSIZE_WORD;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata, q;
  logic         hreadyout, hresp, high_side_switch, hssOe, rstLow, failPin, sleepReq, irq;
  tsrf_events_s events = '0;
  logic         restartEntry = 1'b0;
  int           err_total = 0;
  int           checks_done = 0;
  int           pulses, lowLen, n, hi, sl, act, idle;
  int           onT [16] = '{0, 1, 3, 5, 10, 100, 200, 300, 400, 500, 600, 800, 1000, 1500, 2000, 0};
  int           perMs [6] = '{10, 20, 50, 100, 200, 500};
  logic [4:0]   evMask [8] = '{5'h10, 5'h08, 5'h1f, 5'h04, 5'h02, 5'h01, 5'h1f, 5'h1f};

  always #5 clk_sys = ~clk_sys;

  tsrf_timer_restart_failout #(.TENTH_MS_CYCLES(TQ), .SHORT_CYCLES(SH), .LONG_CYCLES(LG))
    tsrf_timer_restart_failout_inst (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .events(events),
    .restartEntry(restartEntry), .highSideSwitch(high_side_switch), .highSideSwitchOe(hssOe),
    .resetOutputLow(rstLow), .failIndicatorPin(failPin), .sleepRequest(sleepReq), .irq(irq));
  tsrf_host_mon tsrf_host_mon_inst (.clk_sys(clk_sys), .rst(rst), .resetOutputLow(rstLow),
    .pulses(pulses), .lowLen(lowLen));

  task automatic conclude();
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic waitRdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1) begin
      err_total++;
      conclude();
    end
  endtask

  // One single transfer; the idle edge after it lets a write land first
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitRdy();
    q = hrdata;
    @(posedge clk_sys);
  endtask

  task automatic rdChk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(nm, q, exp);
  endtask

  task automatic waitHss(input logic v);
    int k;
    k = 0;
    while (high_side_switch !== v && k < 50000) begin
      @(posedge clk_sys);
      k++;
    end
    if (high_side_switch !== v) begin
      err_total++;
      conclude();
    end
    n += k;
  endtask

  task automatic cntHi(input int len);
    hi = 0;
    repeat (len) begin
      @(posedge clk_sys);
      hi += (high_side_switch === 1'b1);
    end
  endtask

  task automatic doReset();
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    doReset();
    chk("switch oe", hssOe, 0);
    rdChk("timer", IDX_TIMER_B, {24'h0, RST_TIMER_B});
    rdChk("restart", IDX_RESTART, 32'h40);
    rdChk("failout", IDX_FAILOUT, 32'h0);
    xfer(1'b1, 8'h27, 8'hff);
    rdChk("unmapped", 8'h27, 32'h0);
    chk("okay response", hresp, 0);
    xfer(1'b1, IDX_TIMER_B, 8'hf8);
    rdChk("timer rsvd", IDX_TIMER_B, 32'hf0);
    repeat (4) @(posedge clk_sys);
    cntHi(300);
    chk("full on", hi, 300);
    xfer(1'b1, IDX_FAILOUT, 8'hff);
    rdChk("failout rsvd", IDX_FAILOUT, 32'h3e);
    chk("rsvd source pin", failPin, 0);
    // Periods only ascend so the running count never passes the new end
    for (int c = 0; c < 6; c++) begin
      xfer(1'b1, IDX_TIMER_B, {5'h02, c[2:0]});
      waitHss(1'b0);
      waitHss(1'b1);
      n = 0;
      waitHss(1'b0);
      waitHss(1'b1);
      chk("period", n, perMs[c] * 10 * TQ);
    end
    xfer(1'b1, IDX_RESTART, 8'h1f);
    rdChk("limit", IDX_RESTART, 32'h10);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, IDX_FAILOUT, {2'h0, i[0], 5'h00});
      restartEntry <= 1'b1;
      @(posedge clk_sys);
      restartEntry <= 1'b0;
      sl = 0;
      repeat (LG + 10) begin
        @(posedge clk_sys);
        sl += (sleepReq === 1'b1);
      end
      chk("pulses", pulses, (i < 2) ? i + 1 : 2);
      chk("sleep", sl, i == 2);
      // A refused entry makes no pulse, so the last length stays
      chk("low len", lowLen, (i > 0) ? LG : SH);
      rdChk("tally", IDX_RESTART, (i < 2) ? 32'h11 + i : 32'h12);
    end
    chk("irq masked", irq, 0);
    xfer(1'b1, IDX_IRQ_MSK, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq", irq, 1);
    rdChk("overflow flag", IDX_IRQ_ST, 32'h01);
    xfer(1'b1, IDX_IRQ_ST, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", irq, 0);
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 8; s++) begin
        act = (s == 6 || (s < 6 && s != 2)) ? p : !p;
        idle = (s == 6) ? p : !p;
        xfer(1'b1, IDX_FAILOUT, {3'h0, p[0], s[2:0], 1'b0});
        events <= tsrf_events_s'((s == 2 || s > 5) ? 5'h00 : ~evMask[s]);
        @(posedge clk_sys);
        events <= tsrf_events_s'(evMask[s]);
        @(posedge clk_sys);
        events <= '0;
        // Pin seen here still reflects only the other sources
        @(posedge clk_sys);
        chk("other source", failPin, idle);
        repeat (3) @(posedge clk_sys);
        chk("fail pin", failPin, act);
        xfer(1'b1, IDX_IRQ_ST, 8'h3f);
        repeat (2) @(posedge clk_sys);
        chk("fail release", failPin, idle);
      end
    end
    doReset();
    for (int c = 1; c < 15; c++) begin
      xfer(1'b1, IDX_TIMER_B, {c[3:0], (onT[c] <= 1000) ? 4'h3 : 4'h4});
      repeat (4) @(posedge clk_sys);
      cntHi((onT[c] <= 1000) ? 2000 : 4000);
      chk("on time", hi, onT[c] * TQ);
    end
    conclude();
  end
endmodule
`default_nettype wire
